// ==== logic/fcs_cfg.svh ====
// bit layout, encodings and format constants of the fp control/status block
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
`define FCS_CC0_BIT 23
`define FCS_CCU_HI 31
`define FCS_CCU_LO 25
`define FCS_FLUSH_BIT 24
`define FCS_CAUSE_HI 17
`define FCS_CAUSE_LO 12
`define FCS_ENA_HI 11
`define FCS_ENA_LO 7
`define FCS_FLAG_HI 6
`define FCS_FLAG_LO 2
`define FCS_RM_HI 1
`define FCS_RM_LO 0
`define FCS_RSV_HI 22
`define FCS_RSV_LO 18
`define FCS_WMASK 32'hFF83FFFF
`define FCS_RESET_VAL 32'h00000000
`define FCS_IDX_INEXACT 0
`define FCS_IDX_UNDERFLOW 1
`define FCS_IDX_OVERFLOW 2
`define FCS_IDX_DIVZERO 3
`define FCS_IDX_INVALID 4
`define FCS_IDX_UNIMPL 5
`define FCS_SGL_EXP_HI 30
`define FCS_SGL_EXP_LO 23
`define FCS_SGL_FRAC_HI 22
`define FCS_DBL_EXP_HI 62
`define FCS_DBL_EXP_LO 52
`define FCS_DBL_FRAC_HI 51
`define FCS_SGL_SIGN_BIT 31
`define FCS_DBL_SIGN_BIT 63
`define FCS_SGL_BIAS 127
`define FCS_DBL_BIAS 1023
`define FCS_SGL_EMIN_NORM 32'h00800000
`define FCS_DBL_EMIN_NORM 64'h0010000000000000
`endif

// ==== logic/fcs_pkg.sv ====
// types shared by the fp control/status block
`default_nettype none
package fcs_pkg;
    typedef enum logic [1:0] {
        FCS_RND_NEAREST_EVEN,
        FCS_RND_TOWARD_ZERO,
        FCS_RND_TOWARD_PLUS_INF,
        FCS_RND_TOWARD_MINUS_INF
    } fcs_round_t;
    typedef enum logic [2:0] {
        FCS_CLS_ZERO,
        FCS_CLS_DENORMAL,
        FCS_CLS_NORMAL,
        FCS_CLS_INFINITY,
        FCS_CLS_QNAN,
        FCS_CLS_SNAN
    } fcs_class_t;
endpackage
`default_nettype wire

// ==== logic/fcs_cls_if.sv ====
// operand classification carrier between the top and the classifier
`timescale 1ns/1ns
`default_nettype none
interface fcs_cls_if;
    import fcs_pkg::*;
    logic [63:0] operand;
    logic is_double;
    fcs_class_t op_class;
    logic sign;
    modport requester (output operand, output is_double, input op_class, input sign);
    modport classifier (input operand, input is_double, output op_class, output sign);
endinterface
`default_nettype wire

// ==== logic/fcs_classify.sv ====
// combinational ieee operand classifier for single and double formats
`timescale 1ns/1ns
`default_nettype none
`include "fcs_cfg.svh"
module fcs_classify
    import fcs_pkg::*;
(
    fcs_cls_if.classifier cls
);
    wire [7:0] sgl_exp = cls.operand[`FCS_SGL_EXP_HI:`FCS_SGL_EXP_LO];
    wire [22:0] sgl_frac = cls.operand[`FCS_SGL_FRAC_HI:0];
    wire [10:0] dbl_exp = cls.operand[`FCS_DBL_EXP_HI:`FCS_DBL_EXP_LO];
    wire [51:0] dbl_frac = cls.operand[`FCS_DBL_FRAC_HI:0];
    // single: 8-bit exponent; double: 11-bit exponent, 52-bit stored fraction
    wire exp_ones = cls.is_double ? (&dbl_exp) : (&sgl_exp);
    wire exp_zero = cls.is_double ? ~(|dbl_exp) : ~(|sgl_exp);
    wire frac_nz = cls.is_double ? (|dbl_frac) : (|sgl_frac);
    wire frac_msb = cls.is_double ? dbl_frac[`FCS_DBL_FRAC_HI] : sgl_frac[`FCS_SGL_FRAC_HI];
    assign cls.sign = cls.is_double ? cls.operand[`FCS_DBL_SIGN_BIT] : cls.operand[`FCS_SGL_SIGN_BIT];
    always_comb begin
        if (exp_ones && frac_nz) begin
            cls.op_class = frac_msb ? FCS_CLS_SNAN : FCS_CLS_QNAN;
        end else if (exp_ones) begin
            cls.op_class = FCS_CLS_INFINITY;
        end else if (exp_zero && frac_nz) begin
            cls.op_class = FCS_CLS_DENORMAL;
        end else if (exp_zero) begin
            cls.op_class = FCS_CLS_ZERO;
        end else begin
            cls.op_class = FCS_CLS_NORMAL;
        end
    end
endmodule
`default_nettype wire

// ==== logic/fcs_flush.sv ====
// rounding-mode dependent flush value for a denormalized result
`timescale 1ns/1ns
`default_nettype none
`include "fcs_cfg.svh"
module fcs_flush
    import fcs_pkg::*;
(
    input wire logic sign_i,
    input wire logic is_double_i,
    input wire fcs_round_t rnd_i,
    output logic [63:0] value_o
);
    wire to_min_norm = (!sign_i && rnd_i == FCS_RND_TOWARD_PLUS_INF) ||
                       (sign_i && rnd_i == FCS_RND_TOWARD_MINUS_INF);
    wire [63:0] mag = !to_min_norm ? 64'h0000000000000000 :
                      is_double_i ? `FCS_DBL_EMIN_NORM : {32'h00000000, `FCS_SGL_EMIN_NORM};
    assign value_o = is_double_i ? {sign_i, mag[62:0]} : {32'h00000000, sign_i, mag[30:0]};
endmodule
`default_nettype wire

// ==== logic/fcs_top.sv ====
// fp control/status register with compare, cause, enable, flag, flush and rounding logic
`timescale 1ns/1ns
`default_nettype none
`include "fcs_cfg.svh"
module fcs_top
    import fcs_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // control word access from the pipeline
    input wire logic CW_WRITE_I,
    input wire logic [31:0] CW_WDATA_I,
    input wire logic CW_READ_I,
    output logic CW_RVALID_O,
    output logic [31:0] CW_RDATA_O,
    output logic CW_RETRY_O,
    // pipeline drain status
    input wire logic PIPE_BUSY_I,
    // completing fp operation
    input wire logic OP_DONE_I,
    input wire logic OP_IS_ARITH_I,
    input wire logic OP_IS_FUSED_I,
    input wire logic OP_DOUBLE_I,
    input wire logic [4:0] OP_IEEE_EXC_I,
    input wire logic OP_NEEDS_EMUL_I,
    input wire logic OP_RESULT_DENORM_I,
    input wire logic OP_PRODUCT_DENORM_I,
    input wire logic OP_RESULT_SIGN_I,
    input wire logic [63:0] OP_RESULT_I,
    // compare completion
    input wire logic CMP_DONE_I,
    input wire logic [2:0] CMP_SEL_I,
    input wire logic CMP_TRUE_I,
    // operand to classify
    input wire logic [63:0] CLS_OPERAND_I,
    input wire logic CLS_DOUBLE_I,
    // outputs
    output logic EXC_TAKEN_O,
    output logic RES_WRITE_O,
    output logic [63:0] RES_DATA_O,
    output logic [1:0] ROUND_MODE_O,
    output logic [2:0] CLS_CLASS_O,
    output logic CLS_SIGN_O
);
    logic [31:0] csr_q;
    logic [31:0] csr_d;
    logic cw_rvalid_q;
    logic [31:0] cw_rdata_q;
    logic cw_retry_q;
    logic exc_q;
    logic res_wr_q;
    logic [63:0] res_data_q;
    logic [2:0] cls_q;
    logic cls_sign_q;
    logic read_pend_q;

    wire [5:0] cause_cur = csr_q[`FCS_CAUSE_HI:`FCS_CAUSE_LO];
    wire [4:0] enab_cur = csr_q[`FCS_ENA_HI:`FCS_ENA_LO];
    wire [4:0] flag_cur = csr_q[`FCS_FLAG_HI:`FCS_FLAG_LO];
    wire flush_en = csr_q[`FCS_FLUSH_BIT];
    wire fcs_round_t rnd = fcs_round_t'(csr_q[`FCS_RM_HI:`FCS_RM_LO]);

    // flush only when underflow and invalid traps are both disabled
    wire flush_ok = flush_en && !enab_cur[`FCS_IDX_UNDERFLOW] && !enab_cur[`FCS_IDX_INVALID];
    wire fused_unimpl = OP_IS_FUSED_I && OP_PRODUCT_DENORM_I;
    wire denorm_unimpl = OP_RESULT_DENORM_I && !flush_ok;
    wire do_flush = OP_RESULT_DENORM_I && flush_ok && !fused_unimpl;
    wire unimpl = OP_NEEDS_EMUL_I || denorm_unimpl || fused_unimpl;

    // a flushed result is exact by construction only in magnitude; inexact/underflow pass through
    wire [5:0] op_cause = {unimpl, OP_IEEE_EXC_I};
    wire arith_op = OP_DONE_I && OP_IS_ARITH_I;
    wire op_trap = arith_op && (unimpl || |(OP_IEEE_EXC_I & enab_cur));
    // a control write that leaves an enabled cause set traps at once
    wire [31:0] wr_val = CW_WDATA_I & `FCS_WMASK;
    wire wr_trap = CW_WRITE_I && (wr_val[`FCS_CAUSE_HI] ||
                   |(wr_val[`FCS_CAUSE_HI-1:`FCS_CAUSE_LO] & wr_val[`FCS_ENA_HI:`FCS_ENA_LO]));

    wire [63:0] flush_val;
    fcs_flush u_flush (
        .sign_i(OP_RESULT_SIGN_I),
        .is_double_i(OP_DOUBLE_I),
        .rnd_i(rnd),
        .value_o(flush_val)
    );

    fcs_cls_if cls_bus ();
    assign cls_bus.operand = CLS_OPERAND_I;
    assign cls_bus.is_double = CLS_DOUBLE_I;
    fcs_classify u_classify (
        .cls(cls_bus.classifier)
    );

    // next register value; a control write overrides everything in that cycle
    always_comb begin
        csr_d = csr_q;
        if (CW_WRITE_I) begin
            csr_d = wr_val;
        end else begin
            if (CMP_DONE_I) begin
                if (CMP_SEL_I == 3'h0) begin
                    csr_d[`FCS_CC0_BIT] = CMP_TRUE_I;
                end else begin
                    csr_d[`FCS_CCU_LO + {29'h0, CMP_SEL_I} - 32'h1] = CMP_TRUE_I;
                end
            end
            if (arith_op) begin
                csr_d[`FCS_CAUSE_HI:`FCS_CAUSE_LO] = op_cause;
                if (!op_trap) begin
                    csr_d[`FCS_FLAG_HI:`FCS_FLAG_LO] = flag_cur | OP_IEEE_EXC_I;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            csr_q <= `FCS_RESET_VAL;
        end else if (CE_I) begin
            csr_q <= csr_d;
        end
    end

    // result write-back: suppressed on a trap, flushed value on allowed flush
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            exc_q <= 1'b0;
            res_wr_q <= 1'b0;
            res_data_q <= 64'h0000000000000000;
        end else if (CE_I) begin
            exc_q <= op_trap || wr_trap;
            res_wr_q <= arith_op && !op_trap;
            res_data_q <= do_flush ? flush_val : OP_RESULT_I;
        end
    end

    // control read waits for the pipeline to drain; a trap while draining retries it
    wire read_req = CW_READ_I || read_pend_q;
    wire read_fin = read_req && !PIPE_BUSY_I && !op_trap;
    wire read_abort = read_req && op_trap;
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            read_pend_q <= 1'b0;
            cw_rvalid_q <= 1'b0;
            cw_rdata_q <= 32'h00000000;
            cw_retry_q <= 1'b0;
        end else if (CE_I) begin
            read_pend_q <= read_req && !read_fin && !read_abort;
            cw_rvalid_q <= read_fin;
            cw_retry_q <= read_abort;
            if (read_fin) begin
                cw_rdata_q <= csr_q;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cls_q <= 3'h0;
            cls_sign_q <= 1'b0;
        end else if (CE_I) begin
            cls_q <= 3'(cls_bus.op_class);
            cls_sign_q <= cls_bus.sign;
        end
    end

    assign CW_RVALID_O = cw_rvalid_q;
    assign CW_RDATA_O = cw_rdata_q;
    assign CW_RETRY_O = cw_retry_q;
    assign EXC_TAKEN_O = exc_q;
    assign RES_WRITE_O = res_wr_q;
    assign RES_DATA_O = res_data_q;
    assign ROUND_MODE_O = csr_q[`FCS_RM_HI:`FCS_RM_LO];
    assign CLS_CLASS_O = cls_q;
    assign CLS_SIGN_O = cls_sign_q;

    // checks
    sequence s_trap_op;
        CE_I && arith_op && op_trap;
    endsequence
    sequence s_read_idle;
        CE_I && CW_READ_I && !PIPE_BUSY_I && !op_trap && !read_pend_q;
    endsequence

    chk_trap_no_write: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        s_trap_op |=> !RES_WRITE_O && EXC_TAKEN_O)
        else $error("trapping op wrote a result");
    chk_trap_flags_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        s_trap_op and !CW_WRITE_I |=> $stable(csr_q[`FCS_FLAG_HI:`FCS_FLAG_LO]))
        else $error("flags changed on taken exception");
    chk_flag_sticky: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        !CW_WRITE_I |=> ((csr_q[`FCS_FLAG_HI:`FCS_FLAG_LO] & $past(flag_cur)) == $past(flag_cur)))
        else $error("flag cleared without a control write");
    chk_unimpl_traps: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        CE_I && arith_op && unimpl && !CW_WRITE_I |=> EXC_TAKEN_O ##0 csr_q[`FCS_CAUSE_HI])
        else $error("unimplemented cause did not trap");
    chk_cond_stable: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        !CW_WRITE_I && !CMP_DONE_I |=> $stable({csr_q[`FCS_CCU_HI:`FCS_CCU_LO], csr_q[`FCS_CC0_BIT]}))
        else $error("condition bits changed without compare");
    chk_cond_write: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        CE_I && CMP_DONE_I && !CW_WRITE_I && CMP_SEL_I == 3'h0
        |=> csr_q[`FCS_CC0_BIT] == $past(CMP_TRUE_I))
        else $error("condition bit zero not updated");
    chk_cause_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        !CW_WRITE_I && !arith_op |=> $stable(csr_q[`FCS_CAUSE_HI:`FCS_CAUSE_LO]))
        else $error("cause changed by a non-arithmetic op");
    chk_reserved_zero: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        csr_q[`FCS_RSV_HI:`FCS_RSV_LO] == 5'h00)
        else $error("reserved bit set");
    chk_flush_write: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        CE_I && CW_WRITE_I |=> csr_q[`FCS_FLUSH_BIT] == $past(CW_WDATA_I[`FCS_FLUSH_BIT]))
        else $error("flush bit not taken from a control write");
    chk_cause_written: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        CE_I && arith_op && !CW_WRITE_I
        |=> cause_cur[`FCS_IDX_INVALID:`FCS_IDX_INEXACT] == $past(OP_IEEE_EXC_I))
        else $error("cause not rewritten by arithmetic op");
    // back-to-back reads are legal, so only the answer itself is checked
    chk_read_answer: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        s_read_idle |=> CW_RVALID_O && !CW_RETRY_O && CW_RDATA_O == $past(csr_q))
        else $error("idle control read not answered in one cycle");
    chk_flush_value: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        CE_I && do_flush && !OP_RESULT_SIGN_I && rnd == FCS_RND_TOWARD_ZERO
        |=> RES_DATA_O == 64'h0000000000000000)
        else $error("positive flush toward zero not zero");
endmodule
`default_nettype wire

// ==== dv/fcs_host_model.sv ====
// host pipeline model issuing control word moves to the fp block
`timescale 1ns/1ns
`default_nettype none
module fcs_host_model (
    input wire logic clk_i,
    input wire logic pipe_busy_i,
    input wire logic rvalid_i,
    input wire logic retry_i,
    input wire logic [31:0] rdata_i,
    output logic cw_write_o,
    output logic [31:0] cw_wdata_o,
    output logic cw_read_o
);
    initial begin
        cw_write_o = 1'b0;
        cw_wdata_o = 32'h00000000;
        cw_read_o = 1'b0;
    end
    task automatic cw_wr(input logic [31:0] data);
        @(posedge clk_i);
        while (pipe_busy_i) @(posedge clk_i);
        cw_write_o <= 1'b1;
        cw_wdata_o <= data;
        @(posedge clk_i);
        cw_write_o <= 1'b0;
        // stale data is inverted so a late sample cannot pass
        cw_wdata_o <= ~data;
    endtask
    task automatic cw_rd(output logic [31:0] data, output logic retried, output int waited);
        waited = 0;
        @(posedge clk_i);
        cw_read_o <= 1'b1;
        @(posedge clk_i);
        cw_read_o <= 1'b0;
        while (!rvalid_i && !retry_i && waited < 60) begin
            @(posedge clk_i);
            waited++;
        end
        data = rdata_i;
        retried = retry_i;
    endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the fp control/status block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import fcs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cw_write, cw_read, cw_rvalid, cw_retry, exc_taken, res_write, cls_sign;
    logic [31:0] cw_wdata, cw_rdata;
    logic [63:0] res_data;
    logic [1:0] round_mode;
    logic [2:0] cls_class;
    logic pipe_busy = 1'b0, op_done = 1'b0, op_arith = 1'b0, op_fused = 1'b0, op_dbl = 1'b0;
    logic op_emul = 1'b0, op_rden = 1'b0, op_pden = 1'b0, op_sign = 1'b0;
    logic [4:0] op_exc = 5'h00;
    logic cmp_done = 1'b0, cmp_true = 1'b0, cls_dbl = 1'b0, ce = 1'b1;
    logic [2:0] cmp_sel = 3'h0;
    logic [63:0] cls_op = 64'h0;
    localparam logic [63:0] RES = 64'h3FF0000000000000;
    int err_total = 0;
    int checks = 0;
    fcs_top u_fcs_top (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce),
        .CW_WRITE_I(cw_write), .CW_WDATA_I(cw_wdata), .CW_READ_I(cw_read),
        .CW_RVALID_O(cw_rvalid), .CW_RDATA_O(cw_rdata), .CW_RETRY_O(cw_retry),
        .PIPE_BUSY_I(pipe_busy), .OP_DONE_I(op_done), .OP_IS_ARITH_I(op_arith),
        .OP_IS_FUSED_I(op_fused), .OP_DOUBLE_I(op_dbl), .OP_IEEE_EXC_I(op_exc),
        .OP_NEEDS_EMUL_I(op_emul), .OP_RESULT_DENORM_I(op_rden),
        .OP_PRODUCT_DENORM_I(op_pden), .OP_RESULT_SIGN_I(op_sign), .OP_RESULT_I(RES),
        .CMP_DONE_I(cmp_done), .CMP_SEL_I(cmp_sel), .CMP_TRUE_I(cmp_true),
        .CLS_OPERAND_I(cls_op), .CLS_DOUBLE_I(cls_dbl), .EXC_TAKEN_O(exc_taken),
        .RES_WRITE_O(res_write), .RES_DATA_O(res_data), .ROUND_MODE_O(round_mode),
        .CLS_CLASS_O(cls_class), .CLS_SIGN_O(cls_sign));
    fcs_host_model u_fcs_host_model (.clk_i(clk), .pipe_busy_i(pipe_busy),
        .rvalid_i(cw_rvalid), .retry_i(cw_retry), .rdata_i(cw_rdata),
        .cw_write_o(cw_write), .cw_wdata_o(cw_wdata), .cw_read_o(cw_read));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic wrap_up;
        if (err_total == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd_csr(input string name, input logic [31:0] exp);
        logic [31:0] d;
        logic r;
        int n;
        u_fcs_host_model.cw_rd(d, r, n);
        // a read that times out must not pass on stale read data
        check({name, "_done"}, 64'({r, n < 60}), 64'h1);
        check(name, 64'(d), 64'(exp));
    endtask
    task automatic wr(input logic [31:0] v);
        u_fcs_host_model.cw_wr(v);
        #1;
    endtask
    task automatic op(input logic ar, input logic [4:0] ex, input logic em, input logic rd,
                      input logic pd, input logic db, input logic sg);
        @(posedge clk);
        {op_done, op_arith, op_exc, op_emul, op_rden, op_pden, op_fused} <= {2'b11 & {1'b1, ar}, ex, em, rd, pd, pd};
        {op_dbl, op_sign} <= {db, sg};
        @(posedge clk);
        op_done <= 1'b0;
        #1;
    endtask
    task automatic cmp(input logic [2:0] sel, input logic t);
        @(posedge clk);
        {cmp_done, cmp_sel, cmp_true} <= {1'b1, sel, t};
        @(posedge clk);
        cmp_done <= 1'b0;
    endtask
    task automatic t_fields;
        check("round_reset", 64'(round_mode), 64'h0);
        rd_csr("csr_reset", 32'h00000000);
        wr(32'hFFFFFFFF);
        check("exc_on_write", 64'(exc_taken), 64'h1);
        wr(32'hFFFDF07F);
        check("no_exc_write", 64'(exc_taken), 64'h0);
        rd_csr("csr_fields", 32'hFF81F07F);
        for (int m = 0; m < 4; m++) begin
            wr(32'(m));
            check("round_mode", 64'(round_mode), 64'(m));
        end
    endtask
    task automatic t_compare;
        wr(32'h00000000);
        for (int i = 0; i < 8; i++) begin
            cmp(3'(i), 1'b1);
            rd_csr("cond_true", (i == 0) ? 32'h00800000 : (32'h1 << (24 + i)));
            cmp(3'(i), 1'b0);
            rd_csr("cond_false", 32'h00000000);
        end
    endtask
    task automatic t_ops;
        cmp(3'h0, 1'b1);
        op(1'b1, 5'h03, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        check("exc_unenabled", 64'(exc_taken), 64'h0);
        check("res_write", 64'(res_write), 64'h1);
        check("res_data", res_data, RES);
        rd_csr("cause_multi", 32'h0080300C);
        op(1'b0, 5'h1F, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        rd_csr("move_keeps", 32'h0080300C);
        op(1'b1, 5'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        rd_csr("cause_rewrite", 32'h0080000C);
        wr(32'h0080020C);
        op(1'b1, 5'h04, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        check("exc_enabled", 64'(exc_taken), 64'h1);
        check("res_suppress", 64'(res_write), 64'h0);
        rd_csr("flags_kept", 32'h0080420C);
        wr(32'h0080020C);
        check("handler_clear", 64'(exc_taken), 64'h0);
        op(1'b1, 5'h00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        check("exc_unimpl", 64'(exc_taken), 64'h1);
        rd_csr("unimpl_set", 32'h0082020C);
        op(1'b1, 5'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        rd_csr("unimpl_clear", 32'h0080020C);
    endtask
    task automatic t_flush;
        logic [31:0] cw [7] = '{32'h01000002, 32'h01000003, 32'h01000003, 32'h01000002,
            32'h01000000, 32'h01000001, 32'h01000001};
        logic [1:0] ds [7] = '{2'b00, 2'b11, 2'b00, 2'b11, 2'b00, 2'b00, 2'b11};
        logic [63:0] fv [7] = '{64'h00800000, 64'h8010000000000000, 64'h0,
            64'h8000000000000000, 64'h0, 64'h0, 64'h8000000000000000};
        for (int i = 0; i < 7; i++) begin
            wr(cw[i]);
            op(1'b1, 5'h03, 1'b0, 1'b1, 1'b0, ds[i][1], ds[i][0]);
            check("flush_no_exc", 64'(exc_taken), 64'h0);
            check("flush_write", 64'(res_write), 64'h1);
            check("flush_value", res_data, fv[i]);
        end
        op(1'b1, 5'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        check("fused_denorm", 64'(exc_taken), 64'h1);
        // an enabled underflow trap forbids the flush even with the flush bit set
        wr(32'h01000100);
        op(1'b1, 5'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        check("flush_blocked", 64'(exc_taken), 64'h1);
        check("blocked_nowrite", 64'(res_write), 64'h0);
        wr(32'h00000000);
    endtask
    task automatic t_classify;
        logic [63:0] ov [9] = '{64'h7FC00000, 64'h7F800001, 64'hFF800000, 64'h80000000,
            64'h00000001, 64'h3F800000, 64'h7FF8000000000000, 64'h000FFFFFFFFFFFFF,
            64'hBFF0000000000000};
        logic [4:0] ex [9] = '{5'h05, 5'h04, 5'h0B, 5'h08, 5'h01, 5'h02, 5'h15, 5'h11, 5'h1A};
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            {cls_op, cls_dbl} <= {ov[i], ex[i][4]};
            repeat (2) @(posedge clk);
            #1;
            check("cls_class", 64'(cls_class), 64'(ex[i][2:0]));
            check("cls_sign", 64'(cls_sign), 64'(ex[i][3]));
        end
    endtask
    task automatic t_drain;
        logic [31:0] d;
        logic r;
        int n;
        @(posedge clk);
        pipe_busy <= 1'b1;
        fork
            u_fcs_host_model.cw_rd(d, r, n);
            begin
                repeat (5) @(posedge clk);
                pipe_busy <= 1'b0;
            end
        join
        check("drain_wait", 64'(n >= 4), 64'h1);
        check("drain_data", 64'(d), 64'h0);
        wr(32'h00000080);
        @(posedge clk);
        pipe_busy <= 1'b1;
        fork
            u_fcs_host_model.cw_rd(d, r, n);
            begin
                repeat (3) @(posedge clk);
                op(1'b1, 5'h01, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
                pipe_busy <= 1'b0;
            end
        join
        check("drain_retry", 64'(r), 64'h1);
        wr(32'h00000080);
        rd_csr("reissued_read", 32'h00000080);
    endtask
    task automatic t_freeze;
        // a low enable must swallow a compare and a trapping op without trace
        @(posedge clk);
        ce <= 1'b0;
        cmp(3'h0, 1'b1);
        op(1'b1, 5'h1F, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        check("freeze_exc", 64'(exc_taken), 64'h0);
        check("freeze_write", 64'(res_write), 64'h0);
        @(posedge clk);
        ce <= 1'b1;
        rd_csr("freeze_csr", 32'h00000080);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_fields();
        t_compare();
        t_ops();
        t_flush();
        t_classify();
        t_drain();
        t_freeze();
        wrap_up();
    end
    initial begin
        // whole sequence needs well under two thousand cycles
        repeat (20000) @(posedge clk);
        err_total++;
        wrap_up();
    end
endmodule
`default_nettype wire
